/* File: hw/mcsb_bank.v */
// Design decision made here: the Wishbone register port.
`include "mcsb_map.vh"
`default_nettype none

module mcsb_bank
#(
	parameter ADDR_W = 12,
	parameter COUNT_W = `MCSB_CAP_COUNT_W
)
(
	// clock and reset
	input wire clk_sys,
	input wire reset,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADDR_W-1:0] wb_adr_i,
	input wire [7:0] wb_sel_i,
	input wire [63:0] wb_dat_i,
	output wire [63:0] wb_dat_o,
	output wire wb_ack_o,
	// core state at the moment of the error
	input wire mc_error,
	input wire long_mode,
	input wire [63:0] cur_dest_index,
	input wire [63:0] cur_base_pointer,
	input wire [63:0] cur_stack_pointer,
	input wire [63:0] cur_flags,
	input wire [63:0] cur_instr_pointer,
	// trace store page assist or page fault
	input wire trace_store_fault,
	// outputs
	output reg shutdown,
	output reg irq
);

localparam NSAVE = `MCSB_NUM_SAVE;
localparam IDX_W = `MCSB_IDX_W;
localparam IRQ_W = `MCSB_IRQ_W;

function is_idx;
	input [IDX_W-1:0] idx;
	input [IDX_W-1:0] want;
	begin
		is_idx = (idx == want);
	end
endfunction

// byte-lane merge of a write into a stored word
function [63:0] lane_merge;
	input [63:0] old_v;
	input [63:0] new_v;
	input [7:0] sel;
	integer i;
	begin
		lane_merge = old_v;
		for (i = 0; i < 8; i = i + 1)
		begin
			if (sel[i])
				lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
		end
	end
endfunction

wire [IDX_W-1:0] reg_idx;
wire reg_wr;
reg [63:0] rdata_w;

wire [63:0] src_w [0:NSAVE-1];
reg [63:0] save_r [0:NSAVE-1];

reg fault_flag_r;
reg fault_flag_nxt;
reg shutdown_nxt;
reg valid_r;
reg valid_nxt;
reg mode64_r;
reg lock_r;
reg lock_nxt;
reg [COUNT_W-1:0] count_r;
reg [COUNT_W-1:0] count_nxt;
reg [IRQ_W-1:0] irq_stat_r;
reg [IRQ_W-1:0] irq_stat_nxt;
reg [IRQ_W-1:0] irq_en_r;
reg [IRQ_W-1:0] irq_en_nxt;
reg [IRQ_W-1:0] irq_clr_w;
reg [IRQ_W-1:0] irq_ev_w;
reg [63:0] merged_w;

wire cap_go;
wire overrun;
wire wr_misc;
wire wr_en;
wire wr_clr;
wire wr_ctrl;
wire wr_cap;

mcsb_wb_slave
#(
	.ADDR_W(ADDR_W),
	.IDX_W(IDX_W)
)
u_slave
(
	.clk_sys(clk_sys),
	.reset(reset),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.reg_idx(reg_idx),
	.reg_wr(reg_wr),
	.reg_rdata(rdata_w)
);

// save order follows the register order
assign src_w[0] = cur_dest_index;
assign src_w[1] = cur_base_pointer;
assign src_w[2] = cur_stack_pointer;
assign src_w[3] = cur_flags;
assign src_w[4] = cur_instr_pointer;

// lock keeps the first capture until software clears valid
assign cap_go = mc_error & ~(lock_r & valid_r);
assign overrun = mc_error & valid_r;

assign wr_misc = reg_wr & is_idx(reg_idx, `MCSB_IDX_MISC);
assign wr_en = reg_wr & is_idx(reg_idx, `MCSB_IDX_IRQ_EN);
assign wr_clr = reg_wr & is_idx(reg_idx, `MCSB_IDX_IRQ_CLR);
assign wr_ctrl = reg_wr & is_idx(reg_idx, `MCSB_IDX_CTRL);
assign wr_cap = reg_wr & is_idx(reg_idx, `MCSB_IDX_CAP_STAT);

genvar g;
generate
	for (g = 0; g < NSAVE; g = g + 1)
	begin : gen_save
		always @(posedge clk_sys or posedge reset)
		begin
			if (reset)
				save_r[g] <= `MCSB_RST_SAVE;
			else if (cap_go)
			begin
				// upper half zeroed outside 64-bit mode
				if (long_mode)
					save_r[g] <= src_w[g];
				else
					save_r[g] <= {32'h00000000, src_w[g][31:0]};
			end
		end
	end
endgenerate

always @*
begin
	merged_w = lane_merge(64'h0000000000000000, wb_dat_i, wb_sel_i);
	fault_flag_nxt = fault_flag_r;
	// software clears by writing zero to bit 0; event wins
	if (wr_misc & wb_sel_i[0] & ~wb_dat_i[`MCSB_MISC_FAULT_BIT])
		fault_flag_nxt = 1'b0;
	if (trace_store_fault)
		fault_flag_nxt = 1'b1;
end

always @*
begin
	// shutdown holds until reset
	shutdown_nxt = shutdown | trace_store_fault;
end

always @*
begin
	valid_nxt = valid_r;
	count_nxt = count_r;
	// writing zero to valid releases a locked capture
	if (wr_cap & wb_sel_i[0] & ~wb_dat_i[`MCSB_CAP_VALID_BIT])
		valid_nxt = 1'b0;
	if (cap_go)
	begin
		valid_nxt = 1'b1;
		if (count_r != {COUNT_W{1'b1}})
			count_nxt = count_r + {{(COUNT_W-1){1'b0}}, 1'b1};
	end
end

always @*
begin
	lock_nxt = lock_r;
	if (wr_ctrl & wb_sel_i[0])
		lock_nxt = wb_dat_i[`MCSB_CTRL_LOCK_BIT];
end

always @*
begin
	irq_en_nxt = irq_en_r;
	if (wr_en)
		irq_en_nxt = merged_w[IRQ_W-1:0] | (irq_en_r & ~{IRQ_W{wb_sel_i[0]}});
end

always @*
begin
	irq_ev_w = {IRQ_W{1'b0}};
	irq_ev_w[`MCSB_IRQ_CAPTURE] = cap_go;
	irq_ev_w[`MCSB_IRQ_FAULT] = trace_store_fault;
	irq_ev_w[`MCSB_IRQ_OVERRUN] = overrun;
	irq_clr_w = {IRQ_W{1'b0}};
	if (wr_clr & wb_sel_i[0])
		irq_clr_w = wb_dat_i[IRQ_W-1:0];
	// set wins over clear
	irq_stat_nxt = (irq_stat_r & ~irq_clr_w) | irq_ev_w;
end

always @(posedge clk_sys or posedge reset)
begin
	if (reset)
	begin
		fault_flag_r <= 1'b0;
		shutdown <= 1'b0;
		valid_r <= 1'b0;
		mode64_r <= 1'b0;
		lock_r <= `MCSB_RST_CTRL;
		count_r <= `MCSB_RST_COUNT;
		irq_stat_r <= `MCSB_RST_IRQ;
		irq_en_r <= `MCSB_RST_IRQ;
		irq <= 1'b0;
	end
	else
	begin
		fault_flag_r <= fault_flag_nxt;
		shutdown <= shutdown_nxt;
		valid_r <= valid_nxt;
		if (cap_go)
			mode64_r <= long_mode;
		lock_r <= lock_nxt;
		count_r <= count_nxt;
		irq_stat_r <= irq_stat_nxt;
		irq_en_r <= irq_en_nxt;
		irq <= |(irq_stat_nxt & irq_en_nxt);
	end
end

// read mux; unmapped and write-only read as zero
always @*
begin
	rdata_w = 64'h0000000000000000;
	if (is_idx(reg_idx, `MCSB_IDX_DEST))
		rdata_w = save_r[0];
	else if (is_idx(reg_idx, `MCSB_IDX_BASE))
		rdata_w = save_r[1];
	else if (is_idx(reg_idx, `MCSB_IDX_STACK))
		rdata_w = save_r[2];
	else if (is_idx(reg_idx, `MCSB_IDX_FLAGS))
		rdata_w = save_r[3];
	else if (is_idx(reg_idx, `MCSB_IDX_INSTR))
		rdata_w = save_r[4];
	else if (is_idx(reg_idx, `MCSB_IDX_MISC))
		rdata_w[`MCSB_MISC_FAULT_BIT] = fault_flag_r;
	else if (is_idx(reg_idx, `MCSB_IDX_IRQ_STAT))
		rdata_w[IRQ_W-1:0] = irq_stat_r;
	else if (is_idx(reg_idx, `MCSB_IDX_IRQ_EN))
		rdata_w[IRQ_W-1:0] = irq_en_r;
	else if (is_idx(reg_idx, `MCSB_IDX_CTRL))
		rdata_w[`MCSB_CTRL_LOCK_BIT] = lock_r;
	else if (is_idx(reg_idx, `MCSB_IDX_CAP_STAT))
	begin
		rdata_w[`MCSB_CAP_VALID_BIT] = valid_r;
		rdata_w[`MCSB_CAP_MODE64_BIT] = mode64_r;
		rdata_w[`MCSB_CAP_SHUTDOWN_BIT] = shutdown;
		rdata_w[`MCSB_CAP_COUNT_LSB +: COUNT_W] = count_r;
	end
end

endmodule

`default_nettype wire

/* File: hw/mcsb_map.vh */
`ifndef MCSB_MAP_VH
`define MCSB_MAP_VH

// register indices; byte address is eight times the index
`define MCSB_IDX_W 9
`define MCSB_IDX_DEST 9'h185
`define MCSB_IDX_BASE 9'h186
`define MCSB_IDX_STACK 9'h187
`define MCSB_IDX_FLAGS 9'h188
`define MCSB_IDX_INSTR 9'h189
`define MCSB_IDX_MISC 9'h18A
`define MCSB_IDX_IRQ_STAT 9'h1A0
`define MCSB_IDX_IRQ_EN 9'h1A1
`define MCSB_IDX_IRQ_CLR 9'h1A2
`define MCSB_IDX_CTRL 9'h1A3
`define MCSB_IDX_CAP_STAT 9'h1A4

// number of save registers
`define MCSB_NUM_SAVE 5

// misc register fields
`define MCSB_MISC_FAULT_BIT 0

// interrupt status fields
`define MCSB_IRQ_W 3
`define MCSB_IRQ_CAPTURE 0
`define MCSB_IRQ_FAULT 1
`define MCSB_IRQ_OVERRUN 2

// control fields
`define MCSB_CTRL_LOCK_BIT 0

// capture status fields
`define MCSB_CAP_VALID_BIT 0
`define MCSB_CAP_MODE64_BIT 1
`define MCSB_CAP_SHUTDOWN_BIT 2
`define MCSB_CAP_COUNT_LSB 16
`define MCSB_CAP_COUNT_W 16

// reset values
`define MCSB_RST_SAVE 64'h0000000000000000
`define MCSB_RST_IRQ 3'h0
`define MCSB_RST_CTRL 1'h0
`define MCSB_RST_COUNT 16'h0000

`endif

/* File: hw/mcsb_wb_slave.v */
`default_nettype none

module mcsb_wb_slave
#(
	parameter ADDR_W = 12,
	parameter IDX_W = 9
)
(
	// clock and reset
	input wire clk_sys,
	input wire reset,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADDR_W-1:0] wb_adr_i,
	output reg [63:0] wb_dat_o,
	output reg wb_ack_o,
	// register file side
	output wire [IDX_W-1:0] reg_idx,
	output wire reg_wr,
	input wire [63:0] reg_rdata
);

wire req_w;

// byte address to 64-bit word index
assign reg_idx = wb_adr_i[IDX_W+2:3];
assign req_w = wb_cyc_i & wb_stb_i;
// write commits at the edge where the master sees ack
assign reg_wr = req_w & wb_we_i & wb_ack_o;

always @(posedge clk_sys or posedge reset)
begin
	if (reset)
	begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 64'h0000000000000000;
	end
	else
	begin
		wb_ack_o <= req_w & ~wb_ack_o;
		if (req_w & ~wb_ack_o & ~wb_we_i)
			wb_dat_o <= reg_rdata;
	end
end

endmodule

`default_nettype wire

/* File: tb/machine_check_state_save_bank_bench.sv */
`default_nettype none
module machine_check_state_save_bank_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic req = 1'b0;
	logic we = 1'b0;
	logic mc_error = 1'b0;
	logic long_mode = 1'b1;
	logic tsf = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [63:0] wd = 64'h0;
	logic [63:0] v [5] = '{default: 64'h0};
	logic [63:0] q;
	wire logic [63:0] rd;
	wire logic ack;
	wire logic shutdown;
	wire logic irq;
	int failures = 0;
	int checks_done = 0;
	mcsb_bank u_dut (.clk_sys, .reset, .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(8'hFF), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .mc_error, .long_mode,
		.cur_dest_index(v[0]), .cur_base_pointer(v[1]),
		.cur_stack_pointer(v[2]), .cur_flags(v[3]),
		.cur_instr_pointer(v[4]), .trace_store_fault(tsf), .shutdown, .irq);
	initial
		forever #25 clk_sys = ~clk_sys;
	task automatic stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [8:0] i,
		input logic [63:0] d);
		@(posedge clk_sys);
		req <= 1'b1;
		we <= w;
		adr <= {i, 3'h0};
		wd <= d;
		do
		begin
			@(posedge clk_sys);
		end
		while (ack !== 1'b1);
		q = rd;
		req <= 1'b0;
		we <= 1'b0;
		@(negedge clk_sys);
		chk(ack, 64'h0);
	endtask
	task automatic rc(input logic [8:0] i, input logic [63:0] e);
		wb(1'b0, i, 64'h0);
		chk(q, e);
	endtask
	task automatic ev(input logic f);
		@(posedge clk_sys);
		tsf <= f;
		mc_error <= !f;
		@(posedge clk_sys);
		tsf <= 1'b0;
		mc_error <= 1'b0;
		@(negedge clk_sys);
	endtask
	function automatic logic [63:0] cut(logic m, logic [63:0] x);
		return {m ? x[63:32] : 32'h0, x[31:0]};
	endfunction
	task automatic t_cap(input logic m);
		logic [63:0] e [5];
		@(posedge clk_sys);
		long_mode <= m;
		for (int k = 0; k < 5; k++)
		begin
			e[k] = {32'h8000_0001 + 32'(k), 32'h0CAF_E000 + 32'(k + 16 * m)};
			v[k] <= e[k];
		end
		ev(1'b0);
		@(posedge clk_sys);
		foreach (v[k])
			v[k] <= ~v[k];
		for (int k = 0; k < 5; k++)
			rc(9'h185 + 9'(k), cut(m, e[k]));
		wb(1'b1, 9'h188, 64'h0);
		rc(9'h188, cut(m, e[3]));
	endtask
	task automatic t_fault;
		@(negedge clk_sys);
		chk(shutdown, 64'h0);
		ev(1'b1);
		chk(shutdown, 64'h1);
		rc(9'h18A, 64'h1);
		wb(1'b1, 9'h18A, 64'hFFFF_FFFF_FFFF_FFFF);
		rc(9'h18A, 64'h1);
		wb(1'b1, 9'h18A, 64'hFFFF_FFFF_FFFF_FFFE);
		rc(9'h18A, 64'h0);
	endtask
	task automatic t_irq;
		rc(9'h1A0, 64'h7);
		wb(1'b1, 9'h1A1, 64'h1);
		@(negedge clk_sys);
		chk(irq, 64'h1);
		wb(1'b1, 9'h1A2, 64'h7);
		rc(9'h1A0, 64'h0);
		chk(irq, 64'h0);
		ev(1'b0);
		chk(irq, 64'h1);
		wb(1'b1, 9'h1A1, 64'h0);
		@(negedge clk_sys);
		chk(irq, 64'h0);
		rc(9'h18B, 64'h0);
		rc(9'h1A2, 64'h0);
	endtask
	task automatic t_lock;
		@(posedge clk_sys);
		long_mode <= 1'b1;
		v[0] <= 64'h1111_2222_3333_4444;
		ev(1'b0);
		wb(1'b1, 9'h1A3, 64'h1);
		rc(9'h1A3, 64'h1);
		@(posedge clk_sys);
		v[0] <= 64'h5555_6666_7777_8888;
		ev(1'b0);
		rc(9'h185, 64'h1111_2222_3333_4444);
		rc(9'h1A4, 64'h0000_0000_0004_0007);
		wb(1'b1, 9'h1A4, 64'h0);
		ev(1'b0);
		rc(9'h185, 64'h5555_6666_7777_8888);
	endtask
	task automatic t_rst;
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		chk(shutdown, 64'h0);
		rc(9'h189, 64'h0);
	endtask
	initial
	begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		t_cap(1'b1);
		t_cap(1'b0);
		t_fault;
		t_irq;
		t_lock;
		t_rst;
		stop_test;
	end
	initial
	begin
		#200000;
		failures++;
		stop_test;
	end
endmodule
`default_nettype wire

/* File: tb/mcsb_bank_monitor.sv */
`default_nettype none
module mcsb_bank_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [63:0] wb_dat_o,
	input wire logic wb_ack_o,
	// events
	input wire logic mc_error,
	input wire logic trace_store_fault,
	input wire logic shutdown,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack1;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack1: assert property (p_ack1) else $error("ack long");
	property p_shut;
		trace_store_fault |=> shutdown;
	endproperty
	a_shut: assert property (p_shut) else $error("no shutdown");
	property p_hold;
		shutdown |=> shutdown;
	endproperty
	a_hold: assert property (p_hold) else $error("shutdown left");
	property p_nosh;
		!shutdown && !trace_store_fault |=> !shutdown;
	endproperty
	a_nosh: assert property (p_nosh) else $error("stray shutdown");
	property p_misc;
		wb_ack_o && !wb_we_i && wb_adr_i[11:3] == 9'h18A
			|-> wb_dat_o[63:1] == 63'h0;
	endproperty
	a_misc: assert property (p_misc) else $error("misc rsv set");
	property p_gap;
		wb_ack_o && !wb_we_i && wb_adr_i[11:3] == 9'h18B
			|-> wb_dat_o == 64'h0;
	endproperty
	a_gap: assert property (p_gap) else $error("gap not zero");
	property p_irq;
		$rose(irq) |-> $past(mc_error || trace_store_fault || wb_we_i);
	endproperty
	a_irq: assert property (p_irq) else $error("stray irq");
endmodule
bind mcsb_bank mcsb_bank_monitor u_mon (.clk_sys, .reset, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .mc_error,
	.trace_store_fault, .shutdown, .irq);
`default_nettype wire
